// ==== core/srx_consts.svh ====
/*
  constants for the sleep / rotate / subtract / xor execution slice.
  assumes an 8-bit data path and a 7-bit file address space.
*/
// How it works
// - halt clears watchdog counter and prescaler
// - halt clears sleep flag, sets expiry flag
// - halt enters low power, oscillator stopped
// - rotate right file register through carry
// - rotate destination: 0 accumulator, 1 file
// - literal minus accumulator into accumulator
// - literal subtract carry and nibble borrow flags
// - file minus accumulator, routed by destination
// - file subtract carry and nibble borrow flags
// - xor literal into accumulator, zero only
`ifndef SRX_CONSTS_SVH
`define SRX_CONSTS_SVH
`define SRX_CNT_CLEAR   8'h00
`define SRX_PRE_CLEAR   8'h00
`define SRX_ACC_RST     8'h00
`define SRX_DEST_ACC    1'b0
`define SRX_DEST_FILE   1'b1
`define SRX_FLAG_SET    1'b1
`define SRX_FLAG_CLR    1'b0
`define SRX_ADDR_MAX    7'h7f
`endif

// ==== core/srx_exec.sv ====
/*
  executes halt, rotate-right, both subtracts and literal xor.
  assumes the decoder supplies the file operand read at file_addr in the same cycle.
*/
`timescale 1ns/100ps
`default_nettype none
`include "srx_consts.svh"
module srx_exec (
  // clock and reset
  input  wire logic            clk_sys,
  input  wire logic            rst_n,
  // decoded instruction
  input  wire srx_pkg::srx_op_t op,
  input  wire logic            dest_sel,
  input  wire logic [7:0]      literal,
  input  wire logic [6:0]      file_addr,
  input  wire logic [7:0]      file_rdata,
  // wake from low power
  input  wire logic            wake,
  // results
  output logic [7:0]           acc,
  output var srx_pkg::srx_status_t status,
  output logic                 file_we,
  output logic [6:0]           file_waddr,
  output logic [7:0]           file_wdata,
  output logic                 watchdog_counter_clear,
  output logic                 prescaler_clear,
  output logic                 low_power,
  output logic                 osc_stop
);
  srx_pkg::srx_state_t s_q;
  srx_pkg::srx_state_t s_d;
  logic [8:0] diff;
  logic [4:0] ndiff;
  logic [7:0] sub_a;
  logic [7:0] res;

  // ************
  // next state
  // ************
  always_comb begin
    s_d           = s_q;
    s_d.file_we   = 1'b0;
    s_d.cnt_clear = 1'b0;
    sub_a         = (op == srx_pkg::SRX_OP_LSUB) ? literal : file_rdata;
    diff          = {1'b0, sub_a} - {1'b0, s_q.acc};
    ndiff         = {1'b0, sub_a[3:0]} - {1'b0, s_q.acc[3:0]};
    res           = 8'h00;
    if (wake) begin
      s_d.low_power = 1'b0;
    end
    if (!s_q.low_power) begin
      unique case (op)
        srx_pkg::SRX_OP_HALT: begin
          s_d.cnt_clear = 1'b1;
          s_d.status.sleep_entered_flag   = `SRX_FLAG_CLR;
          s_d.status.watchdog_expiry_flag = `SRX_FLAG_SET;
          s_d.low_power = 1'b1;
        end
        srx_pkg::SRX_OP_ROT: begin
          res              = {s_q.status.carry, file_rdata[7:1]};
          s_d.status.carry = file_rdata[0];
          if (dest_sel == `SRX_DEST_ACC) begin
            s_d.acc = res;
          end else begin
            s_d.file_we    = 1'b1;
            s_d.file_addr  = file_addr;
            s_d.file_wdata = res;
          end
        end
        srx_pkg::SRX_OP_LSUB, srx_pkg::SRX_OP_FSUB: begin
          res = diff[7:0];
          // carry and nibble borrow, no borrow means set
          s_d.status.carry              = ~diff[8];
          s_d.status.nibble_borrow_flag = ~ndiff[4];
          s_d.status.zero = (res == 8'h00);
          if (op == srx_pkg::SRX_OP_LSUB || dest_sel == `SRX_DEST_ACC) begin
            s_d.acc = res;
          end else begin
            s_d.file_we    = 1'b1;
            s_d.file_addr  = file_addr;
            s_d.file_wdata = res;
          end
        end
        srx_pkg::SRX_OP_LXOR: begin
          res     = s_q.acc ^ literal;
          s_d.acc = res;
          s_d.status.zero = (res == 8'h00);
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_q                             <= '0;
      s_q.acc                         <= `SRX_ACC_RST;
      s_q.status.watchdog_expiry_flag <= `SRX_FLAG_SET;
      s_q.status.sleep_entered_flag   <= `SRX_FLAG_SET;
    end else begin
      s_q <= s_d;
    end
  end

  // ************
  // outputs
  // ************
  assign acc                    = s_q.acc;
  assign status                 = s_q.status;
  assign file_we                = s_q.file_we;
  assign file_waddr             = s_q.file_addr;
  assign file_wdata             = s_q.file_wdata;
  assign watchdog_counter_clear = s_q.cnt_clear;
  assign prescaler_clear        = s_q.cnt_clear;
  assign low_power              = s_q.low_power;
  assign osc_stop               = s_q.low_power;

  // ************
  // checks
  // ************
  sequence halt_issued;
    op == srx_pkg::SRX_OP_HALT && !low_power;
  endsequence
  sequence halt_done;
    watchdog_counter_clear && prescaler_clear && low_power;
  endsequence

  AST_HALT_CLEAR: assert property (@(posedge clk_sys) disable iff (!rst_n)
    halt_issued |=> halt_done) else $error("halt did not clear watchdog");
  AST_HALT_FLAGS: assert property (@(posedge clk_sys) disable iff (!rst_n)
    halt_issued |=> !status.sleep_entered_flag && status.watchdog_expiry_flag
      && status.carry == $past(status.carry) && status.zero == $past(status.zero))
    else $error("halt flags wrong");
  AST_LOW_POWER: assert property (@(posedge clk_sys) disable iff (!rst_n)
    halt_issued ##1 !wake[*2] |-> low_power && osc_stop) else $error("not asleep");
  AST_ROT_FILE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    op == srx_pkg::SRX_OP_ROT && !low_power && dest_sel |=> file_we
      && file_waddr == $past(file_addr) && status.zero == $past(status.zero))
    else $error("rotate write wrong");
  AST_ROT_ACC: assert property (@(posedge clk_sys) disable iff (!rst_n)
    op == srx_pkg::SRX_OP_ROT && !low_power && !dest_sel |=> !file_we
      && acc == {$past(status.carry), $past(file_rdata[7:1])}) else $error("rotate acc wrong");
  AST_ROT_CARRY: assert property (@(posedge clk_sys) disable iff (!rst_n)
    op == srx_pkg::SRX_OP_ROT && !low_power |=> status.carry == $past(file_rdata[0]))
    else $error("rotate carry wrong");
  AST_LSUB: assert property (@(posedge clk_sys) disable iff (!rst_n)
    op == srx_pkg::SRX_OP_LSUB && !low_power |=> acc == 8'($past(literal) - $past(acc)))
    else $error("literal subtract wrong");
  AST_LSUB_FLAGS: assert property (@(posedge clk_sys) disable iff (!rst_n)
    op == srx_pkg::SRX_OP_LSUB && !low_power |=> status.carry == ($past(acc) <= $past(literal))
      && status.nibble_borrow_flag == ($past(acc[3:0]) <= $past(literal[3:0])))
    else $error("literal subtract flags wrong");
  AST_FSUB: assert property (@(posedge clk_sys) disable iff (!rst_n)
    op == srx_pkg::SRX_OP_FSUB && !low_power && dest_sel |=> file_we
      && file_wdata == 8'($past(file_rdata) - $past(acc))) else $error("file subtract wrong");
  AST_FSUB_FLAGS: assert property (@(posedge clk_sys) disable iff (!rst_n)
    op == srx_pkg::SRX_OP_FSUB && !low_power |=> status.carry == ($past(acc) <= $past(file_rdata)))
    else $error("file subtract carry wrong");
  AST_LXOR: assert property (@(posedge clk_sys) disable iff (!rst_n)
    op == srx_pkg::SRX_OP_LXOR && !low_power |=> acc == ($past(acc) ^ $past(literal))
      && status.carry == $past(status.carry)) else $error("xor wrong");
  AST_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n)
    op == srx_pkg::SRX_OP_LXOR && !low_power |=> status.zero == (acc == 8'h00))
    else $error("zero flag wrong");

  // ************
  // named steps
  // ************

  sequence rot_issued;
    op == srx_pkg::SRX_OP_ROT && !low_power;
  endsequence
  sequence lsub_issued;
    op == srx_pkg::SRX_OP_LSUB && !low_power;
  endsequence
  sequence fsub_issued;
    op == srx_pkg::SRX_OP_FSUB && !low_power;
  endsequence
  sequence fsub_to_file;
    op == srx_pkg::SRX_OP_FSUB && !low_power && dest_sel;
  endsequence
  sequence fsub_to_acc;
    op == srx_pkg::SRX_OP_FSUB && !low_power && !dest_sel;
  endsequence
  sequence lxor_issued;
    op == srx_pkg::SRX_OP_LXOR && !low_power;
  endsequence
  sequence asleep;
    low_power && !wake;
  endsequence
  sequence woken;
    low_power && wake;
  endsequence
  sequence halt_then_wake;
    halt_issued ##1 wake;
  endsequence
  sequence halt_held;
    halt_issued ##1 (!wake)[*4];
  endsequence

  // ************
  // reset and power checks
  // ************

  AST_RESET_VALUES: assert property (@(posedge clk_sys)
    !rst_n |=> acc == `SRX_ACC_RST && !file_we && !watchdog_counter_clear && !low_power
      && status == {`SRX_FLAG_CLR, `SRX_FLAG_CLR, `SRX_FLAG_CLR, `SRX_FLAG_SET, `SRX_FLAG_SET})
    else $error("reset values wrong");

  AST_CLEAR_PULSE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    watchdog_counter_clear |=> !watchdog_counter_clear) else $error("counter clear held");

  AST_PRESCALER_PULSE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    prescaler_clear |=> !prescaler_clear) else $error("prescaler clear held");

  AST_CLEAR_ONLY_HALT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    watchdog_counter_clear |-> $past(op) == srx_pkg::SRX_OP_HALT && !$past(low_power))
    else $error("counter clear without halt");

  AST_OSC_ENTER: assert property (@(posedge clk_sys) disable iff (!rst_n)
    halt_issued |=> $rose(osc_stop)) else $error("oscillator not stopped");

  AST_LP_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    asleep |=> low_power) else $error("left low power without wake");

  AST_LP_STAYS: assert property (@(posedge clk_sys) disable iff (!rst_n)
    halt_held |-> low_power && osc_stop) else $error("low power not kept");

  AST_WAKE_EXIT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    woken |=> !low_power && !osc_stop) else $error("wake ignored");

  AST_HALT_WAKE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    halt_then_wake |=> !low_power) else $error("wake after halt ignored");

  AST_REFUSED: assert property (@(posedge clk_sys) disable iff (!rst_n)
    low_power |=> $stable(acc) && $stable(status) && !file_we && !watchdog_counter_clear)
    else $error("op taken while asleep");

  AST_POWER_ONLY_HALT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(op == srx_pkg::SRX_OP_HALT && !low_power) |=> $stable(status.sleep_entered_flag)
      && $stable(status.watchdog_expiry_flag)) else $error("power flags moved");

  AST_HALT_NO_DATA: assert property (@(posedge clk_sys) disable iff (!rst_n)
    halt_issued |=> !file_we && $stable(acc) && $stable(status.nibble_borrow_flag))
    else $error("halt touched data");

  // ************
  // rotate and write checks
  // ************

  AST_WE_ONLY_WRITES: assert property (@(posedge clk_sys) disable iff (!rst_n)
    file_we |-> ($past(op) == srx_pkg::SRX_OP_ROT || $past(op) == srx_pkg::SRX_OP_FSUB)
      && $past(dest_sel) && !$past(low_power)) else $error("stray file write");

  AST_ROT_KEEP: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rot_issued |=> $stable(status.nibble_borrow_flag) && $stable(status.zero)
      && $stable(status.watchdog_expiry_flag)) else $error("rotate touched other flags");

  AST_ROT_FILE_DATA: assert property (@(posedge clk_sys) disable iff (!rst_n)
    op == srx_pkg::SRX_OP_ROT && !low_power && dest_sel |=> $stable(acc)
      && file_wdata == {$past(status.carry), $past(file_rdata[7:1])})
    else $error("rotate data wrong");

  // ************
  // subtract checks
  // ************

  AST_LSUB_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n)
    lsub_issued |=> status.zero == (acc == 8'h00))
    else $error("literal subtract zero wrong");

  AST_LSUB_NO_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    lsub_issued |=> !file_we && $stable(status.watchdog_expiry_flag))
    else $error("literal subtract wrote file");

  AST_FSUB_ACC: assert property (@(posedge clk_sys) disable iff (!rst_n)
    fsub_to_acc |=> !file_we && acc == 8'($past(file_rdata) - $past(acc)))
    else $error("file subtract acc wrong");

  AST_FSUB_KEEP_ACC: assert property (@(posedge clk_sys) disable iff (!rst_n)
    fsub_to_file |=> $stable(acc) && file_waddr == $past(file_addr))
    else $error("file subtract address wrong");

  AST_FSUB_NIBBLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    fsub_issued |=> status.nibble_borrow_flag == ($past(acc[3:0]) <= $past(file_rdata[3:0])))
    else $error("file subtract nibble flag wrong");

  AST_FSUB_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n)
    fsub_issued |=> status.zero == (8'($past(file_rdata) - $past(acc)) == 8'h00))
    else $error("file subtract zero wrong");

  // ************
  // xor and idle checks
  // ************

  AST_LXOR_KEEP: assert property (@(posedge clk_sys) disable iff (!rst_n)
    lxor_issued |=> !file_we && $stable(status.nibble_borrow_flag)
      && $stable(status.sleep_entered_flag)) else $error("xor touched other state");

  AST_LXOR_ZERO_SET: assert property (@(posedge clk_sys) disable iff (!rst_n)
    lxor_issued |=> status.zero == (($past(acc) ^ $past(literal)) == 8'h00))
    else $error("xor zero wrong");

  AST_IDLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    op == srx_pkg::SRX_OP_NONE && !low_power |=> $stable(acc) && $stable(status) && !file_we)
    else $error("idle cycle changed state");
endmodule
`default_nettype wire

// ==== core/srx_pkg.sv ====
/*
  types for the execution slice.
  assumes the decoder presents one instruction per cycle.
*/
package srx_pkg;
  typedef enum logic [4:0] {
    SRX_OP_NONE  = 5'b0_0000,
    SRX_OP_HALT  = 5'b0_0001,
    SRX_OP_ROT   = 5'b0_0010,
    SRX_OP_LSUB  = 5'b0_0100,
    SRX_OP_FSUB  = 5'b0_1000,
    SRX_OP_LXOR  = 5'b1_0000
  } srx_op_t;

  typedef struct packed {
    logic carry;
    logic nibble_borrow_flag;
    logic zero;
    logic watchdog_expiry_flag;
    logic sleep_entered_flag;
  } srx_status_t;

  typedef struct packed {
    logic [7:0]  acc;
    srx_status_t status;
    logic        file_we;
    logic [6:0]  file_addr;
    logic [7:0]  file_wdata;
    logic        cnt_clear;
    logic        low_power;
  } srx_state_t;
endpackage

// ==== test/srx_file_model.sv ====
/*
  file register space seen by the execution slice.
  assumes writes land on the rising edge after file_we.
*/
`timescale 1ns/100ps
`default_nettype none
module srx_file_model (
  // clock
  input  wire logic       clk_sys,
  // read side
  input  wire logic [6:0] file_addr,
  output logic      [7:0] file_rdata,
  // write side
  input  wire logic       file_we,
  input  wire logic [6:0] file_waddr,
  input  wire logic [7:0] file_wdata
);
  logic [7:0] mem [128];
  initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37);
  assign file_rdata = mem[file_addr];
  always @(posedge clk_sys) if (file_we) mem[file_waddr] <= file_wdata;
endmodule
`default_nettype wire

// ==== test/tb_srx_exec.sv ====
/*
  self-checking bench for the execution slice.
  assumes the file model answers reads in the same cycle.
*/
`timescale 1ns/100ps
`default_nettype none
`define SRX_CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("wrong value t=%0t got %h exp %h", $time, a, b); end end
module tb_srx_exec;
  typedef struct packed {
    logic [7:0]          acc;
    srx_pkg::srx_status_t st;
    logic                we;
    logic [6:0]          wa;
    logic [7:0]          wd;
    logic                clr;
    logic                lp;
  } srx_note_t;
  logic clk_sys = 0, rst_n = 0, dest_sel = 0, wake = 0;
  logic [7:0] literal = 0, file_rdata, acc, file_wdata, f, r;
  logic [6:0] file_addr = 0, file_waddr;
  logic file_we, wdc, prc, low_power, osc_stop;
  srx_pkg::srx_status_t status;
  srx_pkg::srx_op_t op = srx_pkg::SRX_OP_NONE;
  srx_pkg::srx_op_t ops[6] = '{srx_pkg::SRX_OP_NONE, srx_pkg::SRX_OP_HALT, srx_pkg::SRX_OP_ROT,
    srx_pkg::SRX_OP_LSUB, srx_pkg::SRX_OP_FSUB, srx_pkg::SRX_OP_LXOR};
  int n_errors = 0, total_checks = 0, cycles = 0;
  integer seed = 32'h4125;
  srx_note_t q[$], e = '{8'h00, 5'b0_0011, 1'b0, 7'h00, 8'h00, 1'b0, 1'b0}, n;
  always #4 clk_sys = ~clk_sys;
  srx_exec DUT (.clk_sys(clk_sys), .rst_n(rst_n), .op(op), .dest_sel(dest_sel),
    .literal(literal), .file_addr(file_addr), .file_rdata(file_rdata), .wake(wake),
    .acc(acc), .status(status), .file_we(file_we), .file_waddr(file_waddr),
    .file_wdata(file_wdata), .watchdog_counter_clear(wdc), .prescaler_clear(prc),
    .low_power(low_power), .osc_stop(osc_stop));
  srx_file_model u_file (.clk_sys(clk_sys), .file_addr(file_addr), .file_rdata(file_rdata),
    .file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata));
  // route a result by destination
  task automatic put(input logic d);
    if (d) begin
      e.we = 1;
      e.wa = file_addr;
      e.wd = r;
    end else e.acc = r;
  endtask
  // subtract with carry meaning no borrow
  task automatic sub(input logic [7:0] x, input logic d);
    r = x - e.acc;
    e.st.carry = e.acc <= x;
    e.st.nibble_borrow_flag = e.acc[3:0] <= x[3:0];
    e.st.zero = r == 0;
    put(d);
  endtask
  // expected effect of the op now on the inputs
  task automatic step();
    f = u_file.mem[file_addr];
    e.we = 0;
    e.clr = 0;
    if (e.lp) e.lp = !wake;
    else case (op)
      srx_pkg::SRX_OP_HALT: begin
        e.clr = 1;
        e.st.sleep_entered_flag = 0;
        e.st.watchdog_expiry_flag = 1;
        e.lp = 1;
      end
      srx_pkg::SRX_OP_ROT: begin
        r = {e.st.carry, f[7:1]};
        e.st.carry = f[0];
        put(dest_sel);
      end
      srx_pkg::SRX_OP_LSUB: sub(literal, 1'b0);
      srx_pkg::SRX_OP_FSUB: sub(f, dest_sel);
      srx_pkg::SRX_OP_LXOR: begin
        r = e.acc ^ literal;
        e.st.zero = r == 0;
        e.acc = r;
      end
      default: ;
    endcase
    q.push_back(e);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // watcher: one note per driven cycle, asleep cycles included
  always @(posedge clk_sys) begin
    #2;
    if (q.size() > 0) begin
      n = q.pop_front();
      `SRX_CHK(acc, n.acc)
      `SRX_CHK(status, n.st)
      `SRX_CHK(file_we, n.we)
      if (n.we) `SRX_CHK({file_waddr, file_wdata}, {n.wa, n.wd})
      `SRX_CHK({wdc, prc}, {2{n.clr}})
      `SRX_CHK({low_power, osc_stop}, {2{n.lp}})
    end
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles > 5000) begin
      n_errors++;
      complete_run();
    end
  end
  initial begin
    repeat (8) @(negedge clk_sys);
    rst_n = 1;
    @(negedge clk_sys);
    for (int i = 0; i < 3000; i++) begin
      op = ops[$unsigned($random(seed)) % 6];
      dest_sel = 1'($random(seed));
      literal = 8'($random(seed));
      if (($random(seed) & 3) == 0) literal = e.acc;
      file_addr = 7'($random(seed));
      wake = ($random(seed) & 3) == 0;
      step();
      @(negedge clk_sys);
    end
    repeat (2) @(negedge clk_sys);
    complete_run();
  end
endmodule
`default_nettype wire
